// ### hw/cie_core.v
// Instruction execution subset with a classic Wishbone register slave
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "cie_defs.vh"

module cie_core #(
  parameter STACK_DEPTH = 8,
  parameter PTR_W       = 3
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire        core_halted
);

  reg  [7:0]        acc_q;
  reg  [12:0]       pc_q;
  reg               carry_q;
  reg               dcarry_q;
  reg               zero_q;
  reg               powerdown_flag_q;
  reg               timeout_flag_q;
  reg               global_irq_enable_q;
  reg               sleep_q;
  reg               busy_q;
  reg  [7:0]        watchdog_counter_q;
  reg  [7:0]        presc_q;
  reg  [PTR_W-1:0]  sp_q;
  reg  [12:0]       stack_q [0:STACK_DEPTH-1];
  reg  [7:0]        file_q  [0:127];
  reg               ret_wait_q;
  reg  [7:0]        acc_d;
  reg  [12:0]       pc_d;
  reg  [PTR_W-1:0]  sp_d;
  reg               carry_d;
  reg               dcarry_d;
  reg               zero_d;
  reg               global_irq_enable_d;
  reg               powerdown_flag_d;
  reg               timeout_flag_d;
  reg               sleep_d;
  reg  [7:0]        watchdog_counter_d;
  reg  [7:0]        presc_d;

  wire              req      = wb_cyc_i & wb_stb_i;
  wire              do_wr    = req & wb_we_i & wb_ack_o;
  wire              in_file  = wb_adr_i[`CIE_FILE_BIT];
  wire [6:0]        bus_fadr = wb_adr_i[8:2];
  wire              wr_instr = do_wr & ~in_file & (wb_adr_i == `CIE_OFS_INSTR)
                               & wb_sel_i[0] & wb_sel_i[1];
  wire              exec     = wr_instr & ~sleep_q;
  wire [3:0]        op       = wb_dat_i[11:8];
  wire [7:0]        lit      = wb_dat_i[7:0];
  wire [6:0]        fadr     = wb_dat_i[6:0];
  wire              rot_dest = wb_dat_i[`CIE_ROT_DEST];
  wire [7:0]        fval     = file_q[fadr];
  wire [PTR_W-1:0]  sp_top   = sp_q - {{(PTR_W-1){1'b0}}, 1'b1};
  wire [12:0]       stack_top = stack_q[sp_top];
  wire [8:0]        sub_full = {1'b0, lit} - {1'b0, acc_q};
  wire [4:0]        sub_low  = {1'b0, lit[3:0]} - {1'b0, acc_q[3:0]};
  wire [7:0]        rot_val  = {fval[6:0], carry_q};
  wire              is_ret   = (op == `CIE_OP_RET_IRQ) | (op == `CIE_OP_RET_LIT)
                               | (op == `CIE_OP_RETURN);
  wire              reg_wr   = do_wr & ~in_file;
  wire              stall    = busy_q | ret_wait_q;
  wire              acc_wr   = reg_wr & (wb_adr_i == `CIE_OFS_ACC) & wb_sel_i[0];
  wire              stat_wr  = reg_wr & (wb_adr_i == `CIE_OFS_STATUS) & wb_sel_i[0];
  wire              pc_wr    = reg_wr & (wb_adr_i == `CIE_OFS_PC);
  wire              push_wr  = reg_wr & (wb_adr_i == `CIE_OFS_STACK)
                               & wb_sel_i[0] & wb_sel_i[1];
  wire [7:0]        status_rd = {stall, sleep_q, global_irq_enable_q, timeout_flag_q,
                                 powerdown_flag_q, zero_q, dcarry_q, carry_q};

  assign core_halted = sleep_q;

  // Bus answer one cycle after request, held off while a return finishes
  always @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o & ~stall;
      wb_dat_o <= 32'h00000000;
      // Read data only with its ack, never during a stall
      if (req & ~wb_ack_o & ~stall & ~wb_we_i) begin
        if (in_file) begin
          wb_dat_o <= {24'h000000, file_q[bus_fadr]};
        end else begin
          case (wb_adr_i)
            `CIE_OFS_ACC:    wb_dat_o <= {24'h000000, acc_q};
            `CIE_OFS_STATUS: wb_dat_o <= {24'h000000, status_rd};
            `CIE_OFS_PC:     wb_dat_o <= {19'h00000, pc_q};
            `CIE_OFS_STACK:  wb_dat_o <= {19'h00000, stack_top};
            `CIE_OFS_WDOG:   wb_dat_o <= {16'h0000, presc_q, watchdog_counter_q};
            default:         wb_dat_o <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // Two stall cycles after a return push the next answer two cycles later
  always @(posedge ref_clk) begin
    if (rst) begin
      busy_q     <= 1'b0;
      ret_wait_q <= 1'b0;
    end else begin
      busy_q     <= exec & is_ret;
      ret_wait_q <= busy_q;
    end
  end

  // Accumulator next value
  always @* begin
    acc_d = acc_q;
    if (exec) begin
      case (op)
        `CIE_OP_LOAD_LIT: acc_d = lit;
        `CIE_OP_RET_LIT:  acc_d = lit;
        `CIE_OP_ROTATE:   acc_d = rot_dest ? acc_q : rot_val;
        `CIE_OP_SUB_LIT:  acc_d = sub_full[7:0];
        default:          acc_d = acc_q;
      endcase
    end else if (acc_wr) begin
      acc_d = wb_dat_i[7:0];
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      acc_q <= `CIE_RST_ACC;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Arithmetic flags and interrupt enable, next value
  always @* begin
    carry_d             = carry_q;
    dcarry_d            = dcarry_q;
    zero_d              = zero_q;
    global_irq_enable_d = global_irq_enable_q;
    if (exec) begin
      case (op)
        `CIE_OP_ROTATE: carry_d = fval[7];
        `CIE_OP_SUB_LIT: begin
          carry_d  = ~sub_full[8];
          dcarry_d = ~sub_low[4];
          zero_d   = (sub_full[7:0] == 8'h00);
        end
        `CIE_OP_RET_IRQ: global_irq_enable_d = 1'b1;
        default: carry_d = carry_q;
      endcase
    end else if (stat_wr) begin
      carry_d             = wb_dat_i[`CIE_ST_CARRY];
      dcarry_d            = wb_dat_i[`CIE_ST_DCARRY];
      zero_d              = wb_dat_i[`CIE_ST_ZERO];
      global_irq_enable_d = wb_dat_i[`CIE_ST_GIE];
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      carry_q             <= 1'b0;
      dcarry_q            <= 1'b0;
      zero_q              <= 1'b0;
      global_irq_enable_q <= 1'b0;
    end else begin
      carry_q             <= carry_d;
      dcarry_q            <= dcarry_d;
      zero_q              <= zero_d;
      global_irq_enable_q <= global_irq_enable_d;
    end
  end

  // Power-down, time-out and halt state, next value
  always @* begin
    powerdown_flag_d = powerdown_flag_q;
    timeout_flag_d   = timeout_flag_q;
    sleep_d          = sleep_q;
    if (exec & (op == `CIE_OP_SLEEP)) begin
      powerdown_flag_d = 1'b0;
      timeout_flag_d   = 1'b1;
      sleep_d          = 1'b1;
    end else if (stat_wr & wb_dat_i[`CIE_ST_SLEEP]) begin
      sleep_d = 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      powerdown_flag_q <= 1'b1;
      timeout_flag_q   <= 1'b1;
      sleep_q          <= 1'b0;
    end else begin
      powerdown_flag_q <= powerdown_flag_d;
      timeout_flag_q   <= timeout_flag_d;
      sleep_q          <= sleep_d;
    end
  end

  // Watchdog counter and prescaler, frozen while halted
  always @* begin
    watchdog_counter_d = watchdog_counter_q;
    presc_d            = presc_q;
    if (exec & (op == `CIE_OP_SLEEP)) begin
      watchdog_counter_d = `CIE_RST_WDOG;
      presc_d            = `CIE_RST_WDOG;
    end else if (~sleep_q) begin
      presc_d = presc_q + 8'h01;
      if (presc_q == `CIE_PRESC_MAX) begin
        watchdog_counter_d = watchdog_counter_q + 8'h01;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      watchdog_counter_q <= `CIE_RST_WDOG;
      presc_q            <= `CIE_RST_WDOG;
    end else begin
      watchdog_counter_q <= watchdog_counter_d;
      presc_q            <= presc_d;
    end
  end

  // Program counter and stack pointer, next value
  always @* begin
    pc_d = pc_q;
    sp_d = sp_q;
    if (exec) begin
      if (is_ret) begin
        // return loads PC from stack top
        pc_d = stack_top;
        sp_d = sp_top;
      end else if (op != `CIE_OP_SLEEP) begin
        pc_d = pc_q + 13'h0001;
      end
    end else if (pc_wr) begin
      if (wb_sel_i[0]) begin
        pc_d[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        pc_d[12:8] = wb_dat_i[12:8];
      end
    end else if (push_wr) begin
      sp_d = sp_q + {{(PTR_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      pc_q <= `CIE_RST_PC;
      sp_q <= {PTR_W{1'b0}};
    end else begin
      pc_q <= pc_d;
      sp_q <= sp_d;
    end
  end

  // Push fills the slot above the top; the stack wraps silently
  always @(posedge ref_clk) begin
    if (push_wr) begin
      stack_q[sp_q] <= wb_dat_i[12:0];
    end
  end

  // File registers
  always @(posedge ref_clk) begin
    if (exec & (op == `CIE_OP_STORE)) begin
      file_q[fadr] <= acc_q;
    end else if (exec & (op == `CIE_OP_ROTATE) & rot_dest) begin
      file_q[fadr] <= rot_val;
    end else if (do_wr & in_file & wb_sel_i[0]) begin
      file_q[bus_fadr] <= wb_dat_i[7:0];
    end
  end

endmodule
`default_nettype wire

// ### inc/cie_defs.vh
// Constants for the instruction execution subset block
// How it works
// - Load literal puts the 8-bit literal into the accumulator; flags unchanged.
// - Store copies the accumulator into the addressed file register; flags unchanged.
// - Interrupt return loads PC from stack top and sets global interrupt enable.
// - Return with literal writes the literal into the accumulator; flags unchanged.
// - Return with literal reloads PC from stack top and takes two cycles.
// - Subroutine return pops the stack into PC, two cycles, flags untouched.
// - Rotate shifts file register left through carry; only carry changes.
// - Rotate destination bit 0 selects accumulator, 1 selects the file register.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep clears the power-down flag and sets the time-out flag only.
// - Sleep then halts the core; instructions are ignored until a status write sets the sleep bit.
// - Subtract-from-literal writes literal minus accumulator, updating carry, digit carry, zero.
`ifndef CIE_DEFS_VH
`define CIE_DEFS_VH

`define CIE_OFS_INSTR    10'h000
`define CIE_OFS_ACC      10'h004
`define CIE_OFS_STATUS   10'h008
`define CIE_OFS_PC       10'h00C
`define CIE_OFS_STACK    10'h010
`define CIE_OFS_WDOG     10'h014
`define CIE_FILE_BIT     9

`define CIE_OP_NOP       4'h0
`define CIE_OP_LOAD_LIT  4'h1
`define CIE_OP_STORE     4'h2
`define CIE_OP_RET_IRQ   4'h3
`define CIE_OP_RET_LIT   4'h4
`define CIE_OP_RETURN    4'h5
`define CIE_OP_ROTATE    4'h6
`define CIE_OP_SLEEP     4'h7
`define CIE_OP_SUB_LIT   4'h8

`define CIE_ST_CARRY     0
`define CIE_ST_DCARRY    1
`define CIE_ST_ZERO      2
`define CIE_ST_PD        3
`define CIE_ST_TO        4
`define CIE_ST_GIE       5
`define CIE_ST_SLEEP     6
`define CIE_ST_BUSY      7
`define CIE_ROT_DEST     7

`define CIE_RST_ACC      8'h00
`define CIE_RST_PC       13'h0000
`define CIE_RST_WDOG     8'h00
`define CIE_PRESC_MAX    8'hFF

`endif

// ### dv/cie_chk.sv
// Port checks for the execution subset core
`timescale 1ns/1ps
`default_nettype none
module cie_chk (
  input wire        ref_clk,
  input wire        rst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [9:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        core_halted
);
  wire req = wb_cyc_i && wb_stb_i;
  wire ins = wb_ack_o && wb_we_i && wb_adr_i == 10'h000 && (&wb_sel_i[1:0]) && !core_halted;
  wire ret = ins && wb_dat_i[11:8] inside {4'h3, 4'h4, 4'h5};
  wire slp = ins && wb_dat_i[11:8] == 4'h7;
  wire wake = wb_ack_o && wb_we_i && wb_adr_i == 10'h008 && wb_sel_i[0] && wb_dat_i[6];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_has_req: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_ack_in_time: assert property ($rose(req) |-> ##[1:3] wb_ack_o)
    else $error("ack late");
  a_return_two_cyc: assert property (ret |=> !wb_ack_o [*3])
    else $error("return not two cycles");
  a_sleep_halts: assert property (slp |=> core_halted)
    else $error("sleep did not halt");
  a_halt_holds: assert property (core_halted && !wake |=> core_halted)
    else $error("halt dropped");
  a_wake_clears: assert property (core_halted && wake |=> !core_halted)
    else $error("wake ignored");
  a_halt_cause: assert property ($rose(core_halted) |-> $past(slp))
    else $error("halt without sleep");
endmodule
bind cie_core cie_chk u_chk (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_halted(core_halted));
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the execution subset core
`timescale 1ns/1ps
`default_nettype none
`include "cie_defs.vh"
module tb;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [9:0]  adr     = 10'h000;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        halted;
  logic [31:0] q;
  integer      bad_count = 0;
  integer      cmp_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  cie_core dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .core_halted(halted));
  task finish_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: saw %h want %h", $time, s, e);
      end
    end
  endtask
  task xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    integer n;
    begin
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge ref_clk);
      while (ack !== 1'b1) begin
        n = n + 1;
        if (n > 20) begin
          chk(16'h0, 16'h1);
          finish_test;
        end
        @(posedge ref_clk);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task ins(input logic [3:0] op, input logic [7:0] k);
    xfer(1'b1, `CIE_OFS_INSTR, {20'h0, op, k});
  endtask
  task rchk(input logic [9:0] a, input logic [15:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      chk(q[15:0], e);
    end
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    xfer(1'b1, `CIE_OFS_STATUS, 32'h27);
    ins(`CIE_OP_LOAD_LIT, 8'hA5);
    rchk(`CIE_OFS_ACC, 16'h00A5);
    rchk(`CIE_OFS_STATUS, 16'h003F);
    ins(`CIE_OP_STORE, 8'h7F);
    ins(`CIE_OP_STORE, 8'h00);
    rchk(10'h3FC, 16'h00A5);
    rchk(10'h200, 16'h00A5);
    rchk(`CIE_OFS_STATUS, 16'h003F);
    xfer(1'b1, 10'h3FC, 32'h81);
    xfer(1'b1, `CIE_OFS_STATUS, 32'h0);
    ins(`CIE_OP_ROTATE, 8'hFF);
    rchk(10'h3FC, 16'h0002);
    rchk(`CIE_OFS_STATUS, 16'h0019);
    ins(`CIE_OP_ROTATE, 8'h7F);
    rchk(`CIE_OFS_ACC, 16'h0005);
    rchk(10'h3FC, 16'h0002);
    rchk(`CIE_OFS_STATUS, 16'h0018);
    ins(`CIE_OP_SUB_LIT, 8'h03);
    rchk(`CIE_OFS_ACC, 16'h00FE);
    rchk(`CIE_OFS_STATUS, 16'h0018);
    ins(`CIE_OP_SUB_LIT, 8'hFE);
    rchk(`CIE_OFS_STATUS, 16'h001F);
    ins(`CIE_OP_LOAD_LIT, 8'h01);
    ins(`CIE_OP_SUB_LIT, 8'h10);
    rchk(`CIE_OFS_ACC, 16'h000F);
    rchk(`CIE_OFS_STATUS, 16'h0019);
    xfer(1'b1, `CIE_OFS_STACK, 32'h0123);
    xfer(1'b1, `CIE_OFS_STACK, 32'h0456);
    ins(`CIE_OP_RET_LIT, 8'h77);
    rchk(`CIE_OFS_PC, 16'h0456);
    rchk(`CIE_OFS_STACK, 16'h0123);
    ins(`CIE_OP_RETURN, 8'h00);
    rchk(`CIE_OFS_PC, 16'h0123);
    rchk(`CIE_OFS_ACC, 16'h0077);
    rchk(`CIE_OFS_STATUS, 16'h0019);
    xfer(1'b1, `CIE_OFS_STACK, 32'h1ABC);
    ins(`CIE_OP_RET_IRQ, 8'h00);
    rchk(`CIE_OFS_PC, 16'h1ABC);
    rchk(`CIE_OFS_STATUS, 16'h0039);
    ins(`CIE_OP_NOP, 8'h00);
    rchk(`CIE_OFS_PC, 16'h1ABD);
    rchk(`CIE_OFS_ACC, 16'h0077);
    rchk(`CIE_OFS_STATUS, 16'h0039);
    xfer(1'b1, `CIE_OFS_STATUS, 32'h0);
    ins(`CIE_OP_SLEEP, 8'h00);
    chk({15'h0, halted}, 16'h0001);
    rchk(`CIE_OFS_WDOG, 16'h0000);
    rchk(`CIE_OFS_STATUS, 16'h0050);
    ins(`CIE_OP_LOAD_LIT, 8'h11);
    rchk(`CIE_OFS_ACC, 16'h0077);
    xfer(1'b1, `CIE_OFS_STATUS, 32'h40);
    chk({15'h0, halted}, 16'h0000);
    rchk(`CIE_OFS_STATUS, 16'h0010);
    finish_test;
  end
endmodule
`default_nettype wire
